// >>> rtl/bpadc_cfg.svh
`ifndef BPADC_CFG_SVH
`define BPADC_CFG_SVH
// core clock and modulator rate
`define BPADC_CLK_HZ 100000000
`define BPADC_FMOD_HZ 128000
// core cycles per modulator period, rounded down
`define BPADC_MOD_CYC (`BPADC_CLK_HZ / `BPADC_FMOD_HZ)
`define BPADC_MOD_CNT_W 10
// decimation ratio at rate field 0, halved per step
`define BPADC_DEC_MAX 1024
`define BPADC_DEC_W 11
`define BPADC_DR_MAX 3'h6
// filter settles in this many output periods after start
`define BPADC_SETTLE_CONV 2'h3
// input select codes routing leg drive feedback
`define BPADC_MUX_FB_P 4'h6
`define BPADC_MUX_FB_N 4'h7
// output coding
`define BPADC_WORD_W 24
`define BPADC_CODE_MAX 24'h7FFFFF
`define BPADC_CODE_MIN 24'h800000
`define BPADC_CODE_ZERO 24'h000000
// serial frame: status word then channel 1 then channel 2
`define BPADC_FRAME_W 72
`define BPADC_STAT_HDR 4'hC
`endif

// >>> rtl/bpadc_pkg.sv
package bpadc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SETTLE = 3'b010,
    ST_RUN = 3'b100
  } bpadc_state_e;
  typedef logic [23:0] bpadc_word_t;
endpackage

// >>> rtl/bpadc_sat.sv
`timescale 1ns/1ps
`default_nettype none
`include "bpadc_cfg.svh"
module bpadc_sat
  import bpadc_pkg::*;
#(
  parameter int RAW_W = 26
)
(
  input wire logic signed [RAW_W-1:0] raw,
  output logic [23:0] code
);
  if (RAW_W < 24)
  begin : g_bad_width
    $error("bpadc_sat: raw width below 24 bits");
  end
  localparam logic signed [RAW_W-1:0] HI = RAW_W'(signed'(`BPADC_CODE_MAX));
  localparam logic signed [RAW_W-1:0] LO = -HI - RAW_W'(1);
  // clip rather than wrap: wrapping flips sign at full scale
  always_comb
  begin
    if (raw > HI)
      code = `BPADC_CODE_MAX;
    else if (raw < LO)
      code = `BPADC_CODE_MIN;
    else
      code = raw[23:0];
  end
endmodule // bpadc_sat
`default_nettype wire

// >>> rtl/bpadc_ctrl.sv
// Overview of operation
// - results are 24-bit two's complement, msb first
// - full scale clips to 800000h and 7FFFFFh
// - beyond full scale saturates, never wraps
// - code is input over lsb; zero gives zero
// - chip select high floats serial output
// - start to data ready delay is fixed
// - start to data uncertainty within one period
// - select 0110/0111 routes feedback to p/n
// - per-input sense enables; excitation separately off
// - swap bits exchange source and sink inputs
// - two-bit field sets excitation current
// - three-bit field sets comparator threshold
// - comparator status captured, sent in stream
// - comparator power-down disables the comparators
// - ac mode alternates excitation at quarter rate
// - power-up leg drive check needs amp off
// - one rate field sets all channels' decimation
// - clock select chooses source; pin drive gated
`timescale 1ns/1ps
`default_nettype none
`include "bpadc_cfg.svh"
module bpadc_ctrl
  import bpadc_pkg::*;
#(
  parameter int RAW_W = 26
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic signed [RAW_W-1:0] ch1_raw,
  input wire logic signed [RAW_W-1:0] ch2_raw,
  input wire logic [2:0] decimation_rate_field,
  input wire logic [3:0] ch1_input_select,
  input wire logic [3:0] ch2_input_select,
  input wire logic [3:0] electrode_sense_enables,
  input wire logic ch1_excite_polarity_swap,
  input wire logic ch2_excite_polarity_swap,
  input wire logic excite_enable,
  input wire logic ac_mode,
  input wire logic [1:0] excite_current_magnitude,
  input wire logic [2:0] detect_comparator_threshold,
  input wire logic detect_comparator_powerdown,
  input wire logic [3:0] comp_raw,
  input wire logic clock_source_select,
  input wire logic clk_out_en,
  input wire logic leg_drive_amp_powerdown,
  input wire logic leg_drive_check_req,
  output logic data_ready_n,
  output logic dout,
  output logic dout_oe,
  output logic [1:0] fb_to_p,
  output logic [1:0] fb_to_n,
  output logic [3:0] excite_source,
  output logic [3:0] excite_sink,
  output logic [1:0] excite_magnitude,
  output logic [2:0] comp_threshold,
  output logic [3:0] comp_enable,
  output logic [3:0] electrode_detect_status,
  output logic use_internal_osc,
  output logic clk_pin_oe,
  output logic leg_drive_check_en
);
  if (RAW_W < 24 || RAW_W > 32)
  begin : g_bad_width
    $error("bpadc_ctrl: raw width must be 24 to 32");
  end

  localparam logic [9:0] MOD_LAST = 10'(`BPADC_MOD_CYC - 1);

  bpadc_state_e state_r;
  logic start_q_r;
  logic sclk_q_r;
  logic cs_q_r;
  logic [9:0] mod_cnt_r;
  logic [10:0] dec_cnt_r;
  logic [10:0] dec_last_r;
  logic [1:0] settle_cnt_r;
  logic conv_end_r;
  logic ac_cnt_r;
  logic ac_phase_r;
  logic [71:0] frame_r;
  logic [71:0] shift_r;
  logic dout_r;
  logic dout_oe_r;
  logic data_ready_n_r;
  logic [1:0] fb_to_p_r;
  logic [1:0] fb_to_n_r;
  logic [3:0] src_r;
  logic [3:0] snk_r;
  logic [1:0] mag_r;
  logic [2:0] th_r;
  logic [3:0] comp_en_r;
  logic [3:0] status_r;
  logic int_osc_r;
  logic clk_oe_r;
  logic chk_en_r;
  logic start_rise;
  logic mod_tick;
  logic period_end;
  logic sclk_fall;
  logic cs_fall;
  logic [2:0] dr_sat;
  logic [23:0] ch1_code;
  logic [23:0] ch2_code;
  logic [23:0] stat_word;
  logic [1:0] swap;
  logic [3:0] status_nxt;

  assign start_rise = start & ~start_q_r;
  assign mod_tick = (mod_cnt_r == MOD_LAST);
  assign period_end = mod_tick && (dec_cnt_r == dec_last_r);
  assign sclk_fall = sclk_q_r & ~sclk & ~cs_n;
  assign cs_fall = cs_q_r & ~cs_n;
  assign dr_sat = (decimation_rate_field > `BPADC_DR_MAX) ? `BPADC_DR_MAX
                                                        : decimation_rate_field;
  assign swap = {ch2_excite_polarity_swap, ch1_excite_polarity_swap};
  assign status_nxt = detect_comparator_powerdown ? 4'h0
                                                  : comp_raw & electrode_sense_enables;
  assign stat_word = {`BPADC_STAT_HDR, th_r, mag_r, comp_en_r, status_r, 7'h00};

  bpadc_sat #(.RAW_W(RAW_W)) u_sat1 (.raw(ch1_raw), .code(ch1_code));
  bpadc_sat #(.RAW_W(RAW_W)) u_sat2 (.raw(ch2_raw), .code(ch2_code));

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      start_q_r <= 1'b0;
      sclk_q_r <= 1'b0;
      cs_q_r <= 1'b1;
    end
    else
    begin
      start_q_r <= start;
      sclk_q_r <= sclk;
      cs_q_r <= cs_n;
    end
  end

  // start edge restarts the divider so every device lands on the same tick
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || start_rise)
      mod_cnt_r <= 10'h000;
    else if (mod_tick)
      mod_cnt_r <= 10'h000;
    else
      mod_cnt_r <= mod_cnt_r + 10'h001;
  end

  // rate is latched at start and shared by both channels
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      dec_last_r <= 11'(`BPADC_DEC_MAX - 1);
    else if (start_rise)
      dec_last_r <= 11'((`BPADC_DEC_MAX >> dr_sat) - 1);
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || start_rise)
      dec_cnt_r <= 11'h000;
    else if (period_end)
      dec_cnt_r <= 11'h000;
    else if (mod_tick)
      dec_cnt_r <= dec_cnt_r + 11'h001;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      settle_cnt_r <= 2'h0;
      conv_end_r <= 1'b0;
    end
    else if (!start)
    begin
      state_r <= ST_IDLE;
      conv_end_r <= 1'b0;
    end
    else if (start_rise)
    begin
      state_r <= ST_SETTLE;
      settle_cnt_r <= 2'h0;
      conv_end_r <= 1'b0;
    end
    else
    begin
      conv_end_r <= 1'b0;
      case (state_r)
        ST_IDLE:
          state_r <= ST_IDLE;
        ST_SETTLE:
          if (period_end)
          begin
            settle_cnt_r <= settle_cnt_r + 2'h1;
            if (settle_cnt_r == `BPADC_SETTLE_CONV - 2'h1)
            begin
              state_r <= ST_RUN;
              conv_end_r <= 1'b1;
            end
          end
        ST_RUN:
          conv_end_r <= period_end;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // capture both words and the detect state together
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      frame_r <= 72'h0;
      status_r <= 4'h0;
    end
    else if (conv_end_r)
    begin
      frame_r <= {stat_word, ch1_code, ch2_code};
      status_r <= status_nxt;
    end
  end

  // device updates dout after each falling sclk, host samples on the rise
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      shift_r <= 72'h0;
      dout_r <= 1'b0;
    end
    else if (cs_fall)
    begin
      shift_r <= frame_r;
      dout_r <= frame_r[71];
    end
    else if (sclk_fall)
    begin
      shift_r <= {shift_r[70:0], 1'b0};
      dout_r <= shift_r[70];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      dout_oe_r <= 1'b0;
    else
      dout_oe_r <= ~cs_n;
  end

  // new data wins over the read that clears the flag
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !start)
      data_ready_n_r <= 1'b1;
    else if (conv_end_r)
      data_ready_n_r <= 1'b0;
    else if (sclk_fall)
      data_ready_n_r <= 1'b1;
  end

  // ac excitation flips every two conversions: a quarter of the data rate
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !ac_mode || start_rise)
    begin
      ac_cnt_r <= 1'b0;
      ac_phase_r <= 1'b0;
    end
    else if (conv_end_r)
    begin
      ac_cnt_r <= ~ac_cnt_r;
      if (ac_cnt_r)
        ac_phase_r <= ~ac_phase_r;
    end
  end

  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    logic pol;
    // gate with ac_mode so a stale phase cannot leak for a cycle after ac turns off
    assign pol = swap[c] ^ (ac_phase_r & ac_mode);
    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
      begin
        src_r[2*c+1:2*c] <= 2'b00;
        snk_r[2*c+1:2*c] <= 2'b00;
      end
      else
      begin
        // sense may stay on while excitation is off
        src_r[2*c] <= excite_enable & electrode_sense_enables[2*c] & ~pol;
        snk_r[2*c] <= excite_enable & electrode_sense_enables[2*c] & pol;
        src_r[2*c+1] <= excite_enable & electrode_sense_enables[2*c+1] & pol;
        snk_r[2*c+1] <= excite_enable & electrode_sense_enables[2*c+1] & ~pol;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      fb_to_p_r <= 2'b00;
      fb_to_n_r <= 2'b00;
    end
    else
    begin
      fb_to_p_r <= {ch2_input_select == `BPADC_MUX_FB_P,
                    ch1_input_select == `BPADC_MUX_FB_P};
      fb_to_n_r <= {ch2_input_select == `BPADC_MUX_FB_N,
                    ch1_input_select == `BPADC_MUX_FB_N};
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      mag_r <= 2'h0;
      th_r <= 3'h0;
      comp_en_r <= 4'h0;
    end
    else
    begin
      mag_r <= excite_current_magnitude;
      th_r <= detect_comparator_threshold;
      comp_en_r <= electrode_sense_enables & {4{~detect_comparator_powerdown}};
    end
  end

  // shared-clock master election is the board's job; this only gates the pin
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      int_osc_r <= 1'b0;
      clk_oe_r <= 1'b0;
      chk_en_r <= 1'b0;
    end
    else
    begin
      int_osc_r <= clock_source_select;
      clk_oe_r <= clock_source_select & clk_out_en;
      chk_en_r <= leg_drive_check_req & leg_drive_amp_powerdown;
    end
  end

  assign data_ready_n = data_ready_n_r;
  assign dout = dout_r;
  assign dout_oe = dout_oe_r;
  assign fb_to_p = fb_to_p_r;
  assign fb_to_n = fb_to_n_r;
  assign excite_source = src_r;
  assign excite_sink = snk_r;
  assign excite_magnitude = mag_r;
  assign comp_threshold = th_r;
  assign comp_enable = comp_en_r;
  assign electrode_detect_status = status_r;
  assign use_internal_osc = int_osc_r;
  assign clk_pin_oe = clk_oe_r;
  assign leg_drive_check_en = chk_en_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // separate count of conversion ends since the last ac flip
  logic ac_seen_r;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !ac_mode || start_rise)
      ac_seen_r <= 1'b0;
    else if (conv_end_r)
      ac_seen_r <= ~ac_seen_r;
  end

  sequence s_flip_due;
    conv_end_r && ac_seen_r;
  endsequence

  property p_sat_hi;
    conv_end_r && ch1_raw > RAW_W'(signed'(`BPADC_CODE_MAX))
      |=> frame_r[47:24] == `BPADC_CODE_MAX;
  endproperty
  a_sat_hi: assert property (p_sat_hi) else $error("ch1 not clipped high");

  property p_sat_lo;
    conv_end_r && ch2_raw < -RAW_W'(signed'(`BPADC_CODE_MAX)) - RAW_W'(1)
      |=> frame_r[23:0] == `BPADC_CODE_MIN;
  endproperty
  a_sat_lo: assert property (p_sat_lo) else $error("ch2 not clipped low");

  property p_zero;
    conv_end_r && ch1_raw == RAW_W'(0) |=> frame_r[47:24] == `BPADC_CODE_ZERO;
  endproperty
  a_zero: assert property (p_zero) else $error("zero input not zero code");

  property p_msb_first;
    cs_fall |=> dout == frame_r[71] && dout_oe;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit not msb");

  property p_float;
    cs_n [*2] |-> !dout_oe;
  endproperty
  a_float: assert property (p_float) else $error("dout driven while deselected");

  property p_settle;
    start_rise ##1 start [*2] |-> data_ready_n [*2];
  endproperty
  a_settle: assert property (p_settle) else $error("data ready too soon");

  property p_data_ready_n_cause;
    $fell(data_ready_n) |-> $past(conv_end_r);
  endproperty
  a_data_ready_n_cause: assert property (p_data_ready_n_cause) else $error("data ready without conversion");

  property p_fb_mux;
    ch2_input_select == `BPADC_MUX_FB_N |=> fb_to_n[1] && !fb_to_p[1];
  endproperty
  a_fb_mux: assert property (p_fb_mux) else $error("feedback not routed to n");

  property p_excite_off;
    !excite_enable |=> excite_source == 4'h0 && excite_sink == 4'h0;
  endproperty
  a_excite_off: assert property (p_excite_off) else $error("excitation while off");

  property p_swap;
    excite_enable && !ac_mode && ch1_excite_polarity_swap && electrode_sense_enables[0]
      |=> excite_sink[0] && !excite_source[0];
  endproperty
  a_swap: assert property (p_swap) else $error("ch1 polarity not swapped");

  property p_comp_pd;
    detect_comparator_powerdown && conv_end_r |=> electrode_detect_status == 4'h0
      && comp_enable == 4'h0;
  endproperty
  a_comp_pd: assert property (p_comp_pd) else $error("comparators active in power-down");

  property p_ac_quarter;
    (ac_mode && !start_rise) ##0 s_flip_due |=> ac_phase_r != $past(ac_phase_r);
  endproperty
  a_ac_quarter: assert property (p_ac_quarter) else $error("ac phase did not flip");

  property p_ac_hold;
    ac_mode && !start_rise && !(conv_end_r && ac_seen_r) |=> ac_phase_r == $past(ac_phase_r);
  endproperty
  a_ac_hold: assert property (p_ac_hold) else $error("ac phase flipped early");

  property p_clk_pin;
    !clock_source_select |=> !clk_pin_oe && !use_internal_osc;
  endproperty
  a_clk_pin: assert property (p_clk_pin) else $error("clock pin driven on external");

  property p_check_gate;
    !leg_drive_amp_powerdown |=> !leg_drive_check_en;
  endproperty
  a_check_gate: assert property (p_check_gate) else $error("check with amp on");
endmodule // bpadc_ctrl
`default_nettype wire

// >>> verif/bpadc_host.sv
`timescale 1ns/1ps
`default_nettype none
module bpadc_host
(
  input wire logic core_clk,
  input wire logic dout,
  input wire logic dout_oe,
  output logic cs_n,
  output logic sclk
);
  logic last = 1'h0;
  logic line;
  // a released line must not echo the last bit, so show its inverse
  always @(posedge core_clk)
  begin
    if (dout_oe)
      last <= dout;
  end
  assign line = dout_oe ? dout : ~last;
  initial
  begin
    cs_n = 1'h1;
    sclk = 1'h0;
  end
  // sclk stands low outside frames, and is low at the chip select fall
  task automatic read_frame(output logic [71:0] f);
    @(posedge core_clk);
    #1;
    cs_n = 1'h0;
    for (int b = 0; b < 72; b++)
    begin
      repeat (4) @(posedge core_clk);
      #1;
      sclk = 1'h1;
      f = {f[70:0], line};
      repeat (4) @(posedge core_clk);
      #1;
      sclk = 1'h0;
    end
    repeat (4) @(posedge core_clk);
    #1;
    cs_n = 1'h1;
  endtask
endmodule // bpadc_host
`default_nettype wire

// >>> verif/biopotential_adc_output_and_leadoff_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module biopotential_adc_output_and_leadoff_tb_top
  import bpadc_pkg::*;
;
  localparam int P = 781;
  localparam int R = 16;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0, tf, tl;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic start = 1'h0;
  logic cs_n, sclk;
  logic signed [25:0] ch1_raw = '0, ch2_raw = '0;
  logic signed [25:0] vals [10];
  logic [2:0] dr = 3'h0, thr = 3'h0, thro;
  logic [3:0] sel1 = 4'h0, sel2 = 4'h0, sense = 4'h0, comp = 4'h0;
  logic sw1 = 1'h0, sw2 = 1'h0, en = 1'h0, ac = 1'h0, pd = 1'h0;
  logic csel = 1'h0, coe = 1'h0, lpd = 1'h0, lreq = 1'h0;
  logic [1:0] mag = 2'h0, mago, fbp, fbn;
  logic data_ready_n_n, dout, dout_oe, iosc, cpoe, lchk;
  logic [3:0] src, snk, cen, stat;
  logic [3:0] srcs [4], snks [4];
  logic [71:0] f;

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  bpadc_ctrl DUT (.core_clk(core_clk), .rst_n(rst_n), .start(start), .cs_n(cs_n),
    .sclk(sclk), .ch1_raw(ch1_raw), .ch2_raw(ch2_raw), .decimation_rate_field(dr),
    .ch1_input_select(sel1), .ch2_input_select(sel2), .electrode_sense_enables(sense),
    .ch1_excite_polarity_swap(sw1), .ch2_excite_polarity_swap(sw2), .excite_enable(en),
    .ac_mode(ac), .excite_current_magnitude(mag), .detect_comparator_threshold(thr),
    .detect_comparator_powerdown(pd), .comp_raw(comp), .clock_source_select(csel),
    .clk_out_en(coe), .leg_drive_amp_powerdown(lpd), .leg_drive_check_req(lreq),
    .data_ready_n(data_ready_n_n), .dout(dout), .dout_oe(dout_oe), .fb_to_p(fbp), .fb_to_n(fbn),
    .excite_source(src), .excite_sink(snk), .excite_magnitude(mago),
    .comp_threshold(thro), .comp_enable(cen), .electrode_detect_status(stat),
    .use_internal_osc(iosc), .clk_pin_oe(cpoe), .leg_drive_check_en(lchk));

  bpadc_host host (.core_clk(core_clk), .dout(dout), .dout_oe(dout_oe), .cs_n(cs_n),
    .sclk(sclk));

  function automatic logic [23:0] sat(input logic signed [25:0] v);
    if (v > 26'sh07FFFFF)
      return 24'h7FFFFF;
    if (v < -26'sh0800000)
      return 24'h800000;
    return v[23:0];
  endfunction

  // p input gets the source unless its channel is swapped
  function automatic logic [3:0] exc(input logic want_sink);
    logic [3:0] r;
    for (int i = 0; i < 4; i++)
      r[i] = en & sense[i] & (((i % 2) == 0) ^ (i < 2 ? sw1 : sw2) ^ want_sink);
    return r;
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wait_fall(input int bound, output int t);
    int n;
    n = 0;
    while (data_ready_n_n !== 1'h0 && n < bound)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    t = cyc;
    if (n >= bound)
    begin
      mismatches++;
      results();
    end
  endtask

  initial
  begin
    void'($urandom(32'h7B47));
    vals = '{26'sh0800000, 26'sh2000000, 26'sh07FFFFF, -26'sh0800000, 26'sh0000000,
      26'sh0000001, -26'sh0000001, -26'sh0800001, 26'sh0000000, 26'sh0000000};
    repeat (4) @(posedge core_clk);
    #1;
    rst_n = 1'h1;
    for (int k = 0; k < 24; k++)
    begin
      @(posedge core_clk);
      #1;
      {dr, thr, sel1, sel2, sense, comp, mag} = 24'($urandom);
      {sw1, sw2, en, pd, csel, coe, lpd, lreq} = 8'($urandom);
      if (k < 2)
      begin
        sel1 = 4'h6 + 4'(k);
        sel2 = 4'h7 - 4'(k);
      end
      repeat (2) @(posedge core_clk);
      #1;
      `CHK("fb_to_p", {sel2 == 4'h6, sel1 == 4'h6}, fbp)
      `CHK("fb_to_n", {sel2 == 4'h7, sel1 == 4'h7}, fbn)
      `CHK("excite_source", exc(1'h0), src)
      `CHK("excite_sink", exc(1'h1), snk)
      `CHK("excite_magnitude", mag, mago)
      `CHK("comp_threshold", thr, thro)
      `CHK("comp_enable", sense & {4{~pd}}, cen)
      `CHK("use_internal_osc", csel, iosc)
      `CHK("clk_pin_oe", csel & coe, cpoe)
      `CHK("leg_drive_check_en", lreq & lpd, lchk)
      `CHK("data_ready_n idle", 1'h1, data_ready_n_n)
    end
    @(posedge core_clk);
    #1;
    // field value above the top step acts as the top step
    dr = 3'h7;
    sense = 4'hF;
    en = 1'h1;
    ac = 1'h1;
    pd = 1'h0;
    comp = 4'($urandom);
    ch1_raw = vals[0];
    ch2_raw = vals[1];
    @(posedge core_clk);
    #1;
    start = 1'h1;
    t0 = cyc;
    for (int i = 0; i < 4; i++)
    begin
      wait_fall(i == 0 ? 40000 : 14000, tf);
      if (i == 0)
        `CHK("settle", 1'h1, tf - t0 >= 3 * R * P && tf - t0 <= 3 * R * P + 4)
      else
        `CHK("period", R * P, tf - tl)
      tl = tf;
      repeat (2) @(posedge core_clk);
      #1;
      srcs[i] = src;
      snks[i] = snk;
      `CHK("electrode_detect_status", comp, stat)
      ch1_raw = vals[2 * i + 2];
      ch2_raw = vals[2 * i + 3];
      if (i == 0)
        comp = ~comp;
      host.read_frame(f);
      if (i == 0)
        `CHK("status hold", ~comp, stat)
      `CHK("frame status", {4'hC, thr, mag, 4'hF}, f[71:59])
      // frame carries the capture of the period before
      `CHK("frame detect", i == 0 ? 4'h0 : i == 1 ? ~comp : comp, f[58:55])
      `CHK("frame pad", 7'h00, f[54:48])
      `CHK("ch1 word", sat(vals[2 * i]), f[47:24])
      `CHK("ch2 word", sat(vals[2 * i + 1]), f[23:0])
      repeat (2) @(posedge core_clk);
      #1;
      `CHK("dout_oe", 1'h0, dout_oe)
    end
    `CHK("ac excite", snks[0], srcs[2])
    `CHK("ac excite", snks[1], srcs[3])
    // comparator power-down must also blank the next capture
    pd = 1'h1;
    wait_fall(14000, tf);
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("status powered down", 4'h0, stat)
    `CHK("comp_enable powered down", 4'h0, cen)
    results();
  end
endmodule // biopotential_adc_output_and_leadoff_tb_top
`default_nettype wire
